// [hw/afwm_monitor.sv]
// Fault and warning monitor of a class-D amplifier: status, masks, latching, fault and warning pins.
// Assumes a byte register port on the device clock; analog event inputs are asynchronous levels.
//
// Operation
// - Thermal shutdown sets global fault bit 0, forces the outputs to high impedance and drives the fault pin.
// - The thermal shutdown flag stays set until software writes one to bit 7 of the release register.
// - In self-recovery the outputs return to their prior state once the thermal condition is gone.
// - Cycle-limit faults show at global fault bit 2 for the right channel and bit 1 for the left.
// - Warning bit 5 is the left and bit 4 the right cycle-limit warning; bits 7-6 read zero.
// - Warning bits 3 to 0 are the four graded over-temperature warnings, hottest grade highest.
// - A report-mask bit at one keeps its source off the fault pin; the mask resets to zero.
// - Bits 2, 1, 0 of the second pin register hide over-temperature warning, cycle-limit warning and fault.
// - Bits 7 to 3 of that register make their indications sticky, the clock one only with detect-hold set, and reset to one, giving 0xF8.
// - With the detect-hold bit and clock sticky bit 5 both set clock fault status is latched, otherwise it follows the live detection.
// - Bit 4 of the recovery register enables thermal self-recovery and resets to zero.
// - The cycle-limit register holds function, warning and fault enables at bits 2, 1, 0, reset zero.
// - Writing one to bit 7 of the release register clears latched faults; the bit is a write-only strobe.
// - A DC or over-current fault sets a sticky channel bit, forces high impedance and drives the fault pin.
// - A clock fault sets its flag, forces high impedance and recovers by itself when the clock is good.
`timescale 1ns/1ps
`include "afwm_defs.svh"
module afwm_monitor
    import afwm_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire afwm_byte_t reg_addr,
    input wire afwm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output afwm_byte_t reg_rdata,
    input wire logic thermal_shutdown_raw,
    input wire logic left_cycle_limit_fault_raw,
    input wire logic right_cycle_limit_fault_raw,
    input wire logic left_cycle_limit_warn_raw,
    input wire logic right_cycle_limit_warn_raw,
    input wire afwm_grade_t overtemp_warning_raw,
    input wire logic clock_error_raw,
    input wire logic core_supply_under_raw,
    input wire logic core_supply_over_raw,
    input wire logic power_stage_supply_under_raw,
    input wire logic power_stage_supply_over_raw,
    input wire logic left_dc_error_raw,
    input wire logic right_dc_error_raw,
    input wire logic left_overcurrent_raw,
    input wire logic right_overcurrent_raw,
    output logic fault_pin_o,
    output logic fault_pin_oe,
    output logic warn_pin_o,
    output logic warn_pin_oe,
    output logic class_d_hiz
);
    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [17:0] raw_vec;
    logic [17:0] s_vec;
    logic s_therm, s_cbcf_l, s_cbcf_r, s_cbcw_l, s_cbcw_r, s_clk;
    logic s_core_uv, s_core_ov, s_power_stage_supply_uv, s_power_stage_supply_ov, s_dc_l, s_dc_r, s_oc_l, s_oc_r;
    afwm_grade_t s_otw;

    assign raw_vec = {thermal_shutdown_raw, left_cycle_limit_fault_raw, right_cycle_limit_fault_raw,
                      left_cycle_limit_warn_raw, right_cycle_limit_warn_raw, overtemp_warning_raw,
                      clock_error_raw, core_supply_under_raw, core_supply_over_raw,
                      power_stage_supply_under_raw, power_stage_supply_over_raw,
                      left_dc_error_raw, right_dc_error_raw, left_overcurrent_raw, right_overcurrent_raw};

    afwm_sync #(.WIDTH(18)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(raw_vec),
        .sync_out(s_vec)
    );

    assign {s_therm, s_cbcf_l, s_cbcf_r, s_cbcw_l, s_cbcw_r, s_otw, s_clk, s_core_uv, s_core_ov,
            s_power_stage_supply_uv, s_power_stage_supply_ov, s_dc_l, s_dc_r, s_oc_l, s_oc_r} = s_vec;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    afwm_byte_t fault_report_mask;
    afwm_byte_t latch_and_warn_mask;
    afwm_byte_t recovery_detect_ctrl;
    afwm_byte_t cycle_limit_enables;
    afwm_byte_t error_release_cmd;
    logic release_pulse;

    function automatic logic reg_hit(input afwm_byte_t addr, input afwm_byte_t offset);
        reg_hit = (addr == offset);
    endfunction

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_report_mask <= `AFWM_RST_REPORT_MASK;
            latch_and_warn_mask <= `AFWM_RST_LATCH_WARN_MASK;
            recovery_detect_ctrl <= `AFWM_RST_RECOVERY_CTRL;
            cycle_limit_enables <= `AFWM_RST_CYCLE_LIMIT;
            error_release_cmd <= `AFWM_RST_RELEASE_CMD;
        end else if (reg_wr) begin
            if (reg_hit(reg_addr, `AFWM_OFF_REPORT_MASK)) begin
                fault_report_mask <= reg_wdata;
            end
            if (reg_hit(reg_addr, `AFWM_OFF_LATCH_WARN_MASK)) begin
                latch_and_warn_mask <= reg_wdata;
            end
            if (reg_hit(reg_addr, `AFWM_OFF_RECOVERY_CTRL)) begin
                recovery_detect_ctrl <= reg_wdata;
            end
            if (reg_hit(reg_addr, `AFWM_OFF_CYCLE_LIMIT)) begin
                cycle_limit_enables <= reg_wdata;
            end
            if (reg_hit(reg_addr, `AFWM_OFF_RELEASE_CMD)) begin
                error_release_cmd <= {1'b0, reg_wdata[6:0]};
            end
        end
    end

    // Release strobe acts in the write cycle
    assign release_pulse = reg_wr && reg_hit(reg_addr, `AFWM_OFF_RELEASE_CMD)
                           && reg_wdata[`AFWM_BIT_RELEASE];

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    logic cbc_func_en, cycle_limit_warn_gen_en, cbc_err_en, self_recover, detect_hold;
    logic sticky_thermal_shutdown, sticky_cbcf, sticky_cbcw, sticky_otw, sticky_clk;
    logic [15:0] cond_vec, sticky_vec, flag_vec;
    logic f_therm, f_cbcf_l, f_cbcf_r, f_cbcw_l, f_cbcw_r, f_clk;
    logic f_power_stage_supply_ov, f_power_stage_supply_uv, f_dc_l, f_dc_r, f_oc_l, f_oc_r;
    afwm_grade_t f_otw;

    assign cbc_func_en = cycle_limit_enables[`AFWM_BIT_CBC_FUNC];
    assign cycle_limit_warn_gen_en = cycle_limit_enables[`AFWM_BIT_CBC_WARN_GEN];
    assign cbc_err_en = cycle_limit_enables[`AFWM_BIT_CBC_ERR_GEN];
    assign self_recover = recovery_detect_ctrl[`AFWM_BIT_SELF_RECOVER];
    assign detect_hold = recovery_detect_ctrl[`AFWM_BIT_DETECT_HOLD];
    assign sticky_thermal_shutdown = latch_and_warn_mask[`AFWM_BIT_THERMAL_SHUTDOWN_STICKY];
    assign sticky_cbcf = latch_and_warn_mask[`AFWM_BIT_CBC_ERR_STICKY];
    assign sticky_cbcw = latch_and_warn_mask[`AFWM_BIT_CBC_WARN_STICKY];
    assign sticky_otw = latch_and_warn_mask[`AFWM_BIT_OTW_STICKY];
    // Clock status latched only when held and its sticky enable is set
    assign sticky_clk = latch_and_warn_mask[`AFWM_BIT_CLOCK_STICKY] && detect_hold;

    assign cond_vec = {s_therm,
                       s_cbcf_l && cbc_func_en && cbc_err_en,
                       s_cbcf_r && cbc_func_en && cbc_err_en,
                       s_cbcw_l && cbc_func_en && cycle_limit_warn_gen_en,
                       s_cbcw_r && cbc_func_en && cycle_limit_warn_gen_en,
                       s_otw, s_clk, s_power_stage_supply_ov, s_power_stage_supply_uv, s_dc_l, s_dc_r, s_oc_l, s_oc_r};
    assign sticky_vec = {sticky_thermal_shutdown, sticky_cbcf, sticky_cbcf, sticky_cbcw, sticky_cbcw,
                         {4{sticky_otw}}, sticky_clk, 6'h3F};

    afwm_flag #(.WIDTH(16)) u_flag (
        .clock(clock),
        .reset_n(reset_n),
        .cond(cond_vec),
        .sticky(sticky_vec),
        .clear(release_pulse),
        .flag(flag_vec)
    );

    assign {f_therm, f_cbcf_l, f_cbcf_r, f_cbcw_l, f_cbcw_r, f_otw, f_clk,
            f_power_stage_supply_ov, f_power_stage_supply_uv, f_dc_l, f_dc_r, f_oc_l, f_oc_r} = flag_vec;

    // ----------------------------------------
    // Output stage and pins
    // ----------------------------------------
    logic next_hiz, fault_any, warn_any, therm_hold;

    // Self-recovery follows the live condition; otherwise the flag holds shutdown
    assign therm_hold = self_recover ? s_therm : f_therm;
    assign next_hiz = therm_hold || s_therm || s_clk || s_power_stage_supply_ov || s_power_stage_supply_uv
                      || f_dc_l || f_dc_r || f_oc_l || f_oc_r || s_dc_l || s_dc_r || s_oc_l || s_oc_r;

    assign fault_any = (f_therm && !fault_report_mask[`AFWM_BIT_HIDE_THERMAL_SHUTDOWN])
                       || (s_core_uv && !fault_report_mask[`AFWM_BIT_HIDE_CORE_UNDER])
                       || (s_core_ov && !fault_report_mask[`AFWM_BIT_HIDE_CORE_OVER])
                       || (f_clk && !fault_report_mask[`AFWM_BIT_HIDE_CLOCK])
                       || ((f_power_stage_supply_uv || f_power_stage_supply_ov) && !fault_report_mask[`AFWM_BIT_HIDE_POWER_UNDER])
                       || ((f_dc_l || f_dc_r) && !fault_report_mask[`AFWM_BIT_HIDE_DC])
                       || ((f_oc_l || f_oc_r) && !fault_report_mask[`AFWM_BIT_HIDE_OC])
                       || ((f_cbcf_l || f_cbcf_r) && !latch_and_warn_mask[`AFWM_BIT_HIDE_CBC_ERR]);
    assign warn_any = ((|f_otw) && !latch_and_warn_mask[`AFWM_BIT_HIDE_OTW])
                      || ((f_cbcw_l || f_cbcw_r) && !latch_and_warn_mask[`AFWM_BIT_HIDE_CBC_WARN]);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            class_d_hiz <= 1'b0;
        end else begin
            class_d_hiz <= next_hiz;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_pin_o <= 1'b0;
            fault_pin_oe <= 1'b0;
            warn_pin_o <= 1'b0;
            warn_pin_oe <= 1'b0;
        end else begin
            fault_pin_o <= 1'b0;
            warn_pin_o <= 1'b0;
            fault_pin_oe <= fault_any;
            warn_pin_oe <= warn_any;
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    afwm_byte_t next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `AFWM_OFF_CHANNEL_FAULT: next_rdata = {4'h0, f_dc_l, f_dc_r, f_oc_l, f_oc_r};
            `AFWM_OFF_SUPPLY_CLOCK_FAULT: next_rdata = {5'h00, f_clk, f_power_stage_supply_ov, f_power_stage_supply_uv};
            `AFWM_OFF_GLOBAL_FAULT: next_rdata = {5'h00, f_cbcf_r, f_cbcf_l, f_therm};
            `AFWM_OFF_WARN_STATUS: next_rdata = {2'b00, f_cbcw_l, f_cbcw_r, f_otw};
            `AFWM_OFF_REPORT_MASK: next_rdata = fault_report_mask & 8'hF7;
            `AFWM_OFF_LATCH_WARN_MASK: next_rdata = latch_and_warn_mask;
            `AFWM_OFF_RECOVERY_CTRL: next_rdata = recovery_detect_ctrl;
            `AFWM_OFF_CYCLE_LIMIT: next_rdata = cycle_limit_enables;
            `AFWM_OFF_RELEASE_CMD: next_rdata = error_release_cmd;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_thermal_shutdown_sets_flag: assert property (s_therm |=> f_therm && class_d_hiz)
        else $error("thermal shutdown not flagged");
    a_thermal_shutdown_holds_latched: assert property (f_therm && sticky_thermal_shutdown && !release_pulse |=> f_therm)
        else $error("thermal flag dropped without release");
    a_release_clears_thermal_shutdown: assert property (release_pulse && !s_therm |=> !f_therm)
        else $error("release did not clear thermal flag");
    a_self_recover_out: assert property (self_recover && !s_therm && !s_clk && !s_power_stage_supply_ov && !s_power_stage_supply_uv
        && !(|{f_dc_l, f_dc_r, f_oc_l, f_oc_r, s_dc_l, s_dc_r, s_oc_l, s_oc_r}) |=> !class_d_hiz)
        else $error("outputs held after recovery");
    a_cbc_gate_off: assert property (!cbc_func_en && !f_cbcf_l |=> !f_cbcf_l)
        else $error("cycle-limit fault without enable");
    a_dc_fault_sticky: assert property (f_dc_l && !release_pulse |=> f_dc_l ##1 class_d_hiz)
        else $error("DC fault flag not sticky");
    a_clock_fault_hiz: assert property (s_clk |=> f_clk && class_d_hiz)
        else $error("clock fault not reported");
    a_fault_pin_track: assert property (fault_any |=> fault_pin_oe && !fault_pin_o)
        else $error("fault pin not pulled");
    a_warn_pin_track: assert property (!warn_any |=> !warn_pin_oe)
        else $error("warning pin pulled without cause");
    a_otw_live_drop: assert property (!sticky_otw && !s_otw[0] |=> !f_otw[0])
        else $error("live warning did not drop");
    a_release_reads_zero: assert property (reg_rd && reg_hit(reg_addr, `AFWM_OFF_RELEASE_CMD) |=> !reg_rdata[7])
        else $error("release strobe read back");

    c_shutdown_recover: cover property (s_therm ##1 class_d_hiz ##[1:20] !class_d_hiz);
    c_release_latched: cover property (release_pulse && f_therm);
    c_fault_pin_cycle: cover property (fault_pin_oe ##1 !fault_pin_oe);
    c_warn_pin_on: cover property (warn_pin_oe);
endmodule

// [hw/afwm_defs.svh]
// Register offsets, field positions and reset values of the fault and warning monitor.
// Assumes an 8-bit register address and 8-bit register data.
`ifndef AFWM_DEFS_SVH
`define AFWM_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AFWM_OFF_CHANNEL_FAULT 8'h70
`define AFWM_OFF_SUPPLY_CLOCK_FAULT 8'h71
`define AFWM_OFF_GLOBAL_FAULT 8'h72
`define AFWM_OFF_WARN_STATUS 8'h73
`define AFWM_OFF_REPORT_MASK 8'h74
`define AFWM_OFF_LATCH_WARN_MASK 8'h75
`define AFWM_OFF_RECOVERY_CTRL 8'h76
`define AFWM_OFF_CYCLE_LIMIT 8'h77
`define AFWM_OFF_RELEASE_CMD 8'h78

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AFWM_RST_REPORT_MASK 8'h00
`define AFWM_RST_LATCH_WARN_MASK 8'hF8
`define AFWM_RST_RECOVERY_CTRL 8'h00
`define AFWM_RST_CYCLE_LIMIT 8'h00
`define AFWM_RST_RELEASE_CMD 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AFWM_BIT_RELEASE 7
`define AFWM_BIT_DETECT_HOLD 7
`define AFWM_BIT_SELF_RECOVER 4
`define AFWM_BIT_CBC_FUNC 2
`define AFWM_BIT_CBC_WARN_GEN 1
`define AFWM_BIT_CBC_ERR_GEN 0
`define AFWM_BIT_HIDE_THERMAL_SHUTDOWN 7
`define AFWM_BIT_HIDE_CORE_UNDER 6
`define AFWM_BIT_HIDE_CORE_OVER 5
`define AFWM_BIT_HIDE_CLOCK 4
`define AFWM_BIT_MASK_RSVD 3
`define AFWM_BIT_HIDE_POWER_UNDER 2
`define AFWM_BIT_HIDE_DC 1
`define AFWM_BIT_HIDE_OC 0
`define AFWM_BIT_CBC_ERR_STICKY 7
`define AFWM_BIT_CBC_WARN_STICKY 6
`define AFWM_BIT_CLOCK_STICKY 5
`define AFWM_BIT_THERMAL_SHUTDOWN_STICKY 4
`define AFWM_BIT_OTW_STICKY 3
`define AFWM_BIT_HIDE_OTW 2
`define AFWM_BIT_HIDE_CBC_WARN 1
`define AFWM_BIT_HIDE_CBC_ERR 0

`endif

// [hw/afwm_pkg.sv]
// Types shared by the fault and warning monitor.
// Assumes the constants header is compiled alongside.
package afwm_pkg;
    typedef logic [7:0] afwm_byte_t;
    typedef logic [3:0] afwm_grade_t;
endpackage

// [hw/afwm_sync.sv]
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps
module afwm_sync
    import afwm_pkg::*;
#(
    parameter int WIDTH = 19
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// [hw/afwm_flag.sv]
// Bank of status flags, each sticky or live by its own enable.
// Assumes clear is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module afwm_flag
    import afwm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] cond,
    input wire logic [WIDTH-1:0] sticky,
    input wire logic clear,
    output logic [WIDTH-1:0] flag
);
    // Live condition wins over the clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag <= '0;
        end else begin
            flag <= cond | (flag & sticky & {WIDTH{~clear}});
        end
    end
endmodule

// [bench/afwm_host_model.sv]
// Host model: byte register port master and pin observer.
// Assumes the monitor's register timing and pulled-up open-drain pins.
`timescale 1ns/1ps
module afwm_host_model
    import afwm_pkg::*;
(
    input wire logic clock,
    output afwm_byte_t reg_addr,
    output afwm_byte_t reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire afwm_byte_t reg_rdata,
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe,
    input wire logic warn_pin_o,
    input wire logic warn_pin_oe,
    input wire logic class_d_hiz,
    output logic res_valid,
    output afwm_byte_t res_data
);
    // ----------------------------------------
    // Pin levels
    // ----------------------------------------
    logic fault_n;
    logic warn_n;
    assign fault_n = fault_pin_oe ? fault_pin_o : 1'b1;
    assign warn_n = warn_pin_oe ? warn_pin_o : 1'b1;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        res_valid = 1'b0;
        res_data = 8'h00;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic write_reg(input afwm_byte_t a, input afwm_byte_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic read_reg(input afwm_byte_t a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        repeat (2) @(posedge clock);
        res_data <= reg_rdata;
        res_valid <= 1'b1;
        @(posedge clock);
        res_valid <= 1'b0;
    endtask
    task automatic sample_pins();
        repeat (3) @(posedge clock);
        res_data <= {5'b00000, fault_n, warn_n, class_d_hiz};
        res_valid <= 1'b1;
        @(posedge clock);
        res_valid <= 1'b0;
    endtask
endmodule

// [bench/amp_fault_warning_monitor_tb.sv]
// Self-checking bench of the fault and warning monitor.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module amp_fault_warning_monitor_tb
    import afwm_pkg::*;
;
    typedef struct {
        string nm;
        afwm_byte_t v;
    } afwm_note_s;
    logic clock, reset_n, reg_wr, reg_rd, res_valid, ts_raw, clk_raw;
    logic fault_pin_o, fault_pin_oe, warn_pin_o, warn_pin_oe, class_d_hiz;
    afwm_byte_t reg_addr, reg_wdata, reg_rdata, res_data;
    logic [3:0] cbc_raw, dcoc_raw, sup_raw;
    afwm_grade_t otw_raw;
    afwm_note_s notes[$];
    afwm_note_s nt;
    int n_fail = 0, checks = 0, cycles = 0, i;
    logic [31:0] seed;
    afwm_byte_t rst_tab[7] = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'h00, 8'h00};
    afwm_byte_t th_tab[4][6] = '{'{8'h76, 8'h00, 8'h03, 8'h01, 8'h03, 8'h00},
        '{8'h76, 8'h10, 8'h03, 8'h01, 8'h02, 8'h00}, '{8'h74, 8'h80, 8'h07, 8'h01, 8'h07, 8'h00},
        '{8'h75, 8'hE8, 8'h03, 8'h00, 8'h06, 8'hF8}};
    afwm_byte_t cb_tab[2][3] = '{'{8'h09, 8'h02, 8'h10}, '{8'h06, 8'h04, 8'h20}};
    afwm_byte_t sp_tab[4][4] = '{'{8'h40, 8'h00, 8'h02, 8'h06}, '{8'h20, 8'h00, 8'h02, 8'h06},
        '{8'h04, 8'h01, 8'h03, 8'h07}, '{8'h04, 8'h02, 8'h03, 8'h07}};
    // ----------------------------------------
    // Design and host
    // ----------------------------------------
    afwm_monitor afwm_monitor_i (
        .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .thermal_shutdown_raw(ts_raw),
        .left_cycle_limit_fault_raw(cbc_raw[3]), .right_cycle_limit_fault_raw(cbc_raw[2]),
        .left_cycle_limit_warn_raw(cbc_raw[1]), .right_cycle_limit_warn_raw(cbc_raw[0]),
        .overtemp_warning_raw(otw_raw), .clock_error_raw(clk_raw), .core_supply_under_raw(sup_raw[3]),
        .core_supply_over_raw(sup_raw[2]), .power_stage_supply_under_raw(sup_raw[1]),
        .power_stage_supply_over_raw(sup_raw[0]),
        .left_dc_error_raw(dcoc_raw[3]), .right_dc_error_raw(dcoc_raw[2]), .left_overcurrent_raw(dcoc_raw[1]),
        .right_overcurrent_raw(dcoc_raw[0]), .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
        .warn_pin_o(warn_pin_o), .warn_pin_oe(warn_pin_oe), .class_d_hiz(class_d_hiz));
    afwm_host_model afwm_host_model_i (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
        .warn_pin_o(warn_pin_o), .warn_pin_oe(warn_pin_oe), .class_d_hiz(class_d_hiz),
        .res_valid(res_valid), .res_data(res_data));
    // ----------------------------------------
    // Helpers and result checking
    // ----------------------------------------
    always #2.5 clock = ~clock;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic settle();
        repeat (6) @(posedge clock);
    endtask
    task automatic wr(input afwm_byte_t a, input afwm_byte_t d);
        afwm_host_model_i.write_reg(a, d);
    endtask
    task automatic rd(input afwm_byte_t a, input afwm_byte_t v);
        notes.push_back('{nm: $sformatf("reg %h", a), v: v});
        afwm_host_model_i.read_reg(a);
    endtask
    task automatic pins(input afwm_byte_t v);
        notes.push_back('{nm: "pins", v: v});
        afwm_host_model_i.sample_pins();
    endtask
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (res_valid === 1'b1) begin
            nt = notes.pop_front();
            checks = checks + 1;
            if (res_data !== nt.v) begin
                n_fail = n_fail + 1;
                $display("Error %s expected %h seen %h", nt.nm, nt.v, res_data);
            end
        end
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            $display("Error timeout expected done seen running");
            give_verdict();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        ts_raw = 1'b0;
        clk_raw = 1'b0;
        cbc_raw = 4'h0;
        dcoc_raw = 4'h0;
        otw_raw = 4'h0;
        sup_raw = 4'h0;
        seed = 32'h4b42_8eb1;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(afwm_byte_t'(8'h73 + i), rst_tab[i]);
        end
        for (i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            wr(afwm_byte_t'(8'h74 + i), seed[7:0]);
            rd(afwm_byte_t'(8'h74 + i), (i == 0) ? (seed[7:0] & 8'hF7) : seed[7:0]);
            wr(afwm_byte_t'(8'h74 + i), rst_tab[i + 1]);
        end
        wr(8'h78, 8'hD5);
        rd(8'h78, 8'h55);
        wr(8'h73, 8'hFF);
        rd(8'h73, 8'h00);
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            wr(th_tab[i][0], th_tab[i][1]);
            @(posedge clock) ts_raw <= 1'b1;
            settle();
            rd(8'h72, 8'h01);
            pins(th_tab[i][2]);
            @(posedge clock) ts_raw <= 1'b0;
            settle();
            rd(8'h72, th_tab[i][3]);
            pins(th_tab[i][4]);
            wr(8'h78, 8'h80);
            rd(8'h72, 8'h00);
            pins(8'h06);
            wr(th_tab[i][0], th_tab[i][5]);
        end
        $display("test thermal done");
        wr(8'h75, 8'hF0);
        for (i = 0; i < 4; i++) begin
            @(posedge clock) otw_raw <= afwm_grade_t'(1 << i);
            settle();
            rd(8'h73, afwm_byte_t'(1 << i));
            pins(8'h04);
        end
        wr(8'h75, 8'hF4);
        pins(8'h06);
        wr(8'h75, 8'hF8);
        @(posedge clock) otw_raw <= 4'h0;
        settle();
        wr(8'h78, 8'h80);
        $display("test warnings done");
        for (i = 0; i < 2; i++) begin
            @(posedge clock) cbc_raw <= cb_tab[i][0][3:0];
            settle();
            rd(8'h72, 8'h00);
            wr(8'h77, 8'h07);
            settle();
            rd(8'h72, cb_tab[i][1]);
            rd(8'h73, cb_tab[i][2]);
            pins(8'h00);
            wr(8'h75, 8'hFA);
            pins(8'h02);
            wr(8'h75, 8'hF9);
            pins(8'h04);
            @(posedge clock) cbc_raw <= 4'h0;
            settle();
            rd(8'h72, cb_tab[i][1]);
            wr(8'h78, 8'h80);
            rd(8'h73, 8'h00);
            wr(8'h75, 8'hF8);
            wr(8'h77, 8'h00);
        end
        $display("test cycle limit done");
        for (i = 0; i < 4; i++) begin
            @(posedge clock) dcoc_raw <= 4'(1 << i);
            settle();
            @(posedge clock) dcoc_raw <= 4'h0;
            settle();
            rd(8'h70, afwm_byte_t'(1 << i));
            pins(8'h03);
            wr(8'h74, (i < 2) ? 8'h01 : 8'h02);
            pins(8'h07);
            wr(8'h74, 8'h00);
            wr(8'h78, 8'h80);
            rd(8'h70, 8'h00);
        end
        $display("test channel faults done");
        for (i = 0; i < 2; i++) begin
            wr(8'h76, (i == 1) ? 8'h80 : 8'h00);
            @(posedge clock) clk_raw <= 1'b1;
            settle();
            rd(8'h71, 8'h04);
            pins(8'h03);
            wr(8'h74, 8'h10);
            pins(8'h07);
            wr(8'h74, 8'h00);
            @(posedge clock) clk_raw <= 1'b0;
            settle();
            rd(8'h71, (i == 1) ? 8'h04 : 8'h00);
            pins((i == 1) ? 8'h02 : 8'h06);
            wr(8'h78, 8'h80);
            rd(8'h71, 8'h00);
        end
        $display("test clock fault done");
        for (i = 0; i < 4; i++) begin
            @(posedge clock) sup_raw <= 4'(8 >> i);
            settle();
            rd(8'h71, sp_tab[i][1]);
            pins(sp_tab[i][2]);
            wr(8'h74, sp_tab[i][0]);
            pins(sp_tab[i][3]);
            @(posedge clock) sup_raw <= 4'h0;
            settle();
            wr(8'h74, 8'h00);
            wr(8'h78, 8'h80);
            rd(8'h71, 8'h00);
        end
        $display("test supplies done");
        @(posedge clock);
        give_verdict();
    end
endmodule
